// *** include/dbc_pkg.sv ***
/*
 * Shared constants and types for the DMA command decoder and byte counter.
 * Assumes a 100 MHz core clock and a 32-bit APB register port.
 */
package dbc_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] CMD_ADDR       = 8'h30;
	localparam logic [7:0] COUNTER_ADDR   = 8'h34;
	localparam logic [7:0] CTRL_ADDR      = 8'h3c;
	localparam logic [7:0] STATUS_ADDR    = 8'h40;
	localparam logic [7:0] TFDATA_ADDR    = 8'h44;

	// ==========================================================
	// Field positions and reset values
	localparam int CTRL_DIS_CNT_BIT     = 0;
	localparam int CTRL_BURST_LSB       = 16;
	localparam int STAT_GSTOP_BIT       = 0;
	localparam int STAT_TFDONE_BIT      = 1;
	localparam int STAT_BUSY_BIT        = 8;
	localparam int STAT_FCNT_LSB        = 16;
	localparam logic [31:0] COUNTER_RST = 32'h0000_0000;
	localparam logic [15:0] BURST_RST   = 16'h0000;

	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_GEN_IN   = 8'h00;
	localparam logic [7:0] CMD_GEN_OUT  = 8'h01;
	localparam logic [7:0] CMD_MW_IN    = 8'h06;
	localparam logic [7:0] CMD_MW_OUT   = 8'h07;
	localparam logic [7:0] CMD_CORE_RST = 8'h11;
	localparam logic [7:0] CMD_MW_STOP  = 8'h12;
	localparam logic [7:0] CMD_GEN_STOP = 8'h13;
	localparam logic [7:0] CMD_TF_FIRST = 8'h21;
	localparam logic [7:0] CMD_TF_LAST  = 8'h28;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ      = 100;
	localparam int DRAIN_NS     = 60;  // Longest FIFO to buffer delay
	localparam int DRAIN_CYC    = (DRAIN_NS * CLK_MHZ) / 1000;
	localparam int RST_PULSE_NS = 40;  // Handshake glitch during core reset
	localparam int RST_CYC      = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int PIO_NS       = 600; // Least task-file read strobe
	localparam int PIO_CYC      = (PIO_NS * CLK_MHZ + 999) / 1000;
	localparam int FIFO_DEPTH   = 8;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {ST_IDLE, ST_XFER, ST_PIO, ST_CORE_RST} dbc_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} dbc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} dbc_apb_rsp_t;

	typedef struct packed {
		logic        dreq;
		logic        dack_n;
		logic        diow_n;
		logic        dior_n;
	} dbc_hs_t;

	typedef struct packed {
		logic        wr;
		logic [63:0] data;
		logic [3:0]  cnt;
		logic        keep;
	} dbc_ep_t;

endpackage

// *** core/dbc_core.sv ***
/*
 * DMA command decoder, transfer byte counter and 8-byte IN FIFO drain.
 * Assumes APB from the system side; the strobe and data pins come from the
 * external DMA bus asynchronously and are synchronised here.
 */
`timescale 1ns/100ps

// Overview of operation
// R01 - An 8-bit command code written to the command register selects one action.
// R02 - Code 11h returns the whole DMA core to its power-on state.
// R03 - During core reset the handshake lines pulse asserted, then go idle.
// R04 - External controller waits until core reset ends before using handshake lines.
// R05 - Code 12h stops a multiword transfer at once; only for 06h/07h transfers.
// R06 - Code 13h stops a generic transfer; unmoved OUT data stays in buffer. Here EP.keep drops as soon as the stop ends the transfer.
// R07 - Generic stop flushes remaining IN FIFO bytes into the endpoint buffer.
// R08 - Completion of the generic stop sets a status bit.
// R09 - Generic stop during an OUT burst waits for the burst boundary.
// R10 - Codes 21h to 28h read one task-file register and flag completion.
// R11 - Reserved codes start nothing and change no core state.
// R12 - Four-byte counter at 34h holds the byte count for the next transfer.
// R13 - Counter shows bytes remaining, counting down as bytes move.
// R14 - With counting disabled the counter still decrements and wraps past zero.
// R15 - IN FIFO holds up to 8 bytes, moved to endpoint buffer within 60 ns.
// R16 - OUT endpoint buffer stays valid until the transfer has read it all.
module dbc_core (
	input  wire logic                  CLK,
	input  wire logic                  RST,
	input  wire dbc_pkg::dbc_apb_req_t APB_REQ,
	output dbc_pkg::dbc_apb_rsp_t      APB_RSP,
	input  wire logic                  BUS_STROBE,
	input  wire logic [15:0]           BUS_DATA,
	output dbc_pkg::dbc_hs_t           HS,
	output logic [9:0]                 TF_ADDR,
	output dbc_pkg::dbc_ep_t           EP
);
	import dbc_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		dbc_state_t        state;
		logic [3:0]        rst_cnt;
		logic [6:0]        pio_cnt;
		logic [7:0]        cmd;
		logic [31:0]       count;
		logic              dis_cnt;
		logic [15:0]       burst_len;
		logic [15:0]       burst_pos;
		logic              stop_pend;
		logic              mw_mode;
		logic              dir_in;
		logic              gdone;
		logic              tfdone;
		logic [15:0]       tfdata;
		logic [9:0]        tfaddr;
		logic [7:0][7:0]   fifo;
		logic [3:0]        fcnt;
		logic [2:0]        age;
		logic [2:0]        stb_sync;
		logic              stb_stable;
		logic [15:0]       d1;
		logic [15:0]       d2;
		logic [15:0]       d3;
		dbc_apb_rsp_t      rsp;
		dbc_hs_t           hs;
		dbc_ep_t           ep;
	} dbc_regs_t;

	dbc_regs_t r;
	dbc_regs_t next_r;

	// Reset image, shared by RST and the core reset command
	// Synchronisers restart too, so a pin held high reads as an edge only in a transfer
	localparam dbc_regs_t RESET_VAL = '{
		state:      ST_IDLE,
		rst_cnt:    4'h0,
		pio_cnt:    7'h00,
		cmd:        8'h00,
		count:      COUNTER_RST,
		dis_cnt:    1'b0,
		burst_len:  BURST_RST,
		burst_pos:  16'h0000,
		stop_pend:  1'b0,
		mw_mode:    1'b0,
		dir_in:     1'b0,
		gdone:      1'b0,
		tfdone:     1'b0,
		tfdata:     16'h0000,
		tfaddr:     10'h000,
		fifo:       64'h0,
		fcnt:       4'h0,
		age:        3'h0,
		stb_sync:   3'h0,
		stb_stable: 1'b0,
		d1:         16'h0000,
		d2:         16'h0000,
		d3:         16'h0000,
		rsp:        '{prdata: 32'h0, pready: 1'b0, pslverr: 1'b0},
		hs:         '{dreq: 1'b0, dack_n: 1'b1, diow_n: 1'b1, dior_n: 1'b1},
		ep:         '{wr: 1'b0, data: 64'h0, cnt: 4'h0, keep: 1'b0}
	};

	// Task-file address for each single-register read code
	// Only the read codes reach this function; other codes never enter the PIO state
	function automatic logic [9:0] tf_addr_of(input logic [7:0] code);
		logic [9:0] a;
		a = 10'h000;
		unique case (code)
			8'h27:   a = 10'h3f6;
			8'h28:   a = 10'h3f7;
			default: a = 10'h1f0 + {6'h00, code[3:0]}; // 21h..26h map to 1F1h..1F6h
		endcase
		return a;
	endfunction

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic        setup;
		logic        wr_acc;
		logic        byte_evt;
		logic        flush;
		logic        in_stop;
		logic [3:0]  base;
		logic [7:0]  code;
		logic        mapped;
		logic [31:0] rd;
		logic        core_rst;

		next_r   = r;
		setup    = 1'b0;
		wr_acc   = 1'b0;
		byte_evt = 1'b0;
		flush    = 1'b0;
		in_stop  = 1'b0;
		base     = 4'h0;
		code     = APB_REQ.pwdata[7:0];
		mapped   = 1'b0;
		rd       = 32'h0;
		core_rst = 1'b0;

		// Pin synchronisers: a change counts once stages two and three agree
		// The data pipe matches the strobe pipe, so the byte taken with a counted edge
		// is the one that stood on the pins when the strobe rose
		next_r.stb_sync = {r.stb_sync[1:0], BUS_STROBE};
		next_r.d1 = BUS_DATA;
		next_r.d2 = r.d1;
		next_r.d3 = r.d2;
		if (r.stb_sync[1] == r.stb_sync[2] && r.stb_sync[2] != r.stb_stable) begin
			next_r.stb_stable = r.stb_sync[2];
			byte_evt = r.stb_sync[2] && r.state == ST_XFER; // Rising edge moves one byte
		end

		// APB: answer in the access cycle that follows every setup cycle
		// Read data is captured at setup, so the access cycle shows a settled word
		// Unmapped offsets answer with an error and read as zero; writes there are dropped
		setup  = APB_REQ.psel && !APB_REQ.penable;
		wr_acc = APB_REQ.psel && APB_REQ.penable && r.rsp.pready && APB_REQ.pwrite;
		mapped = APB_REQ.paddr inside {CMD_ADDR, COUNTER_ADDR, CTRL_ADDR, STATUS_ADDR,
			TFDATA_ADDR};
		unique case (APB_REQ.paddr)
			CMD_ADDR:     rd = {24'h0, r.cmd};
			COUNTER_ADDR: rd = r.count;                                         // R12
			CTRL_ADDR:    rd = {r.burst_len, 15'h0, r.dis_cnt};
			STATUS_ADDR:  rd = {12'h0, r.fcnt, 7'h0, (r.state != ST_IDLE), 6'h0, r.tfdone,
				r.gdone};
			TFDATA_ADDR:  rd = {16'h0, r.tfdata};
			default:      rd = 32'h0;
		endcase
		next_r.rsp.pready  = setup;
		next_r.rsp.pslverr = setup && !mapped;
		if (setup) begin
			next_r.rsp.prdata = rd;
		end

		// Write-one-to-clear status; a set later in this process wins
		// Busy and FIFO level are live views and take no writes
		if (wr_acc && APB_REQ.paddr == STATUS_ADDR) begin
			if (APB_REQ.pwdata[STAT_GSTOP_BIT]) begin
				next_r.gdone = 1'b0;
			end
			if (APB_REQ.pwdata[STAT_TFDONE_BIT]) begin
				next_r.tfdone = 1'b0;
			end
		end
		if (wr_acc && APB_REQ.paddr == CTRL_ADDR) begin
			next_r.dis_cnt   = APB_REQ.pwdata[CTRL_DIS_CNT_BIT];
			next_r.burst_len = APB_REQ.pwdata[CTRL_BURST_LSB +: 16];
		end

		// Byte movement: counter and burst position
		// Counting goes on with counting disabled; only the end-of-transfer test is skipped
		if (byte_evt) begin
			next_r.count = r.count - 32'h1; // R13 R14
			if (r.burst_len != 16'h0) begin
				next_r.burst_pos = (r.burst_pos + 16'h1 == r.burst_len) ? 16'h0
					: r.burst_pos + 16'h1;
			end
			if (!r.dis_cnt && r.count == 32'h1) begin
				next_r.state = ST_IDLE;     // Counter ran out, transfer ends
			end
		end

		// Burst boundary reached with a generic OUT stop waiting; a transfer that the
		// counter ends first completes the stop as well, else a stale request would
		// cut the next transfer short at its first burst boundary
		if (r.stop_pend && (next_r.state != ST_XFER
			|| (byte_evt && next_r.burst_pos == 16'h0))) begin
			next_r.stop_pend = 1'b0;   // R09
			next_r.state     = ST_IDLE;
			next_r.gdone     = 1'b1;   // R08
		end

		// Command decode, one action per code
		// Start codes act only from idle; a code written mid-transfer is kept for read-back
		if (wr_acc && APB_REQ.paddr == CMD_ADDR) begin
			next_r.cmd = code; // R01
			if (code == CMD_CORE_RST) begin
				// The access carrying this write still completes on the bus
				next_r         = RESET_VAL;                       // R02
				core_rst       = 1'b1;
				next_r.cmd     = code;
				next_r.state   = ST_CORE_RST;
				next_r.rst_cnt = 4'(RST_CYC);
				next_r.rsp     = r.rsp;
				next_r.rsp.pready = 1'b0;
			end else if (code == CMD_MW_STOP) begin
				if (r.state == ST_XFER && r.mw_mode) begin
					next_r.state = ST_IDLE; // R05
				end
			end else if (code == CMD_GEN_STOP) begin
				if (r.state == ST_XFER && !r.mw_mode && !r.dir_in && r.burst_len != 16'h0
					&& r.burst_pos != 16'h0) begin
					next_r.stop_pend = 1'b1; // R09
				end else if (r.state != ST_XFER || !r.mw_mode) begin
					// Stop while idle still reports done, so no flag is ever lost
					if (r.state == ST_XFER) begin
						next_r.state = ST_IDLE; // R06
					end
					in_stop      = r.dir_in;
					next_r.gdone = 1'b1;  // R08
				end
			end else if (r.state == ST_IDLE) begin
				if (code inside {CMD_GEN_IN, CMD_GEN_OUT, CMD_MW_IN, CMD_MW_OUT}) begin
					next_r.state     = ST_XFER;
					next_r.mw_mode   = code[2];
					next_r.dir_in    = !code[0];
					next_r.burst_pos = 16'h0;
				end else if (code >= CMD_TF_FIRST && code <= CMD_TF_LAST) begin
					next_r.state   = ST_PIO;                   // R10
					next_r.tfaddr  = tf_addr_of(code);
					next_r.pio_cnt = 7'(PIO_CYC);
				end
			end
			// Reserved codes fall through with no effect on the core R11
		end

		// Counter write wins over a decrement in the same cycle
		// A write in mid-transfer simply restarts the count from the new value
		if (wr_acc && APB_REQ.paddr == COUNTER_ADDR) begin
			next_r.count = APB_REQ.pwdata; // R12
		end

		// State sequencing; a core reset written this cycle overrides any count in flight
		unique case (core_rst ? ST_IDLE : r.state)
			ST_IDLE, ST_XFER: begin
			end
			ST_PIO: begin
				next_r.pio_cnt = r.pio_cnt - 7'h1;
				// Data taken on the last strobe cycle, once the pin pipe has settled
				if (r.pio_cnt == 7'h1) begin
					next_r.tfdata = r.d3;   // Data sampled at end of strobe R10
					next_r.tfdone = 1'b1;   // R10
					next_r.state  = ST_IDLE;
				end
			end
			ST_CORE_RST: begin
				next_r.rst_cnt = r.rst_cnt - 4'h1;
				// Handshake lines stay asserted for the whole count
				if (r.rst_cnt == 4'h1) begin
					next_r.state = ST_IDLE; // External side may start from here R04
				end
			end
		endcase

		// IN FIFO: drained whole, when full, when old or on generic stop
		// The age limit keeps every byte within the drain bound at this clock; a full
		// FIFO drains at once so a strobe already in the synchroniser still finds room
		next_r.ep.wr = 1'b0;
		flush = r.fcnt != 4'h0 && (r.fcnt == 4'(FIFO_DEPTH) || r.age == 3'(DRAIN_CYC - 1)
			|| in_stop); // R07 R15
		if (r.state == ST_CORE_RST || next_r.state == ST_CORE_RST) begin
			flush = 1'b0;
		end
		base = r.fcnt;
		if (flush) begin
			next_r.ep.wr   = 1'b1;
			next_r.ep.data = r.fifo;
			next_r.ep.cnt  = r.fcnt;
			base           = 4'h0;
			next_r.fcnt    = 4'h0;
			next_r.age     = 3'h0;
		end else if (r.fcnt != 4'h0) begin
			next_r.age = r.age + 3'h1;
		end
		if (byte_evt && r.dir_in && next_r.state != ST_CORE_RST) begin
			next_r.fifo[base[2:0]] = r.d3[7:0];
			next_r.fcnt            = base + 4'h1;
		end

		// Handshake outputs: pulsed asserted during core reset, else normal use
		if (next_r.state == ST_CORE_RST) begin
			next_r.hs = '{dreq: 1'b1, dack_n: 1'b0, diow_n: 1'b0, dior_n: 1'b0}; // R03
		end else begin
			// A pending generic stop keeps requesting, since the burst must reach its end
			// The request drops one byte early: a strobe in the synchroniser may still land
			next_r.hs.dreq   = next_r.state == ST_XFER && (r.dis_cnt || next_r.count != 32'h0)
				&& next_r.fcnt < 4'(FIFO_DEPTH - 1); // R09
			next_r.hs.dack_n = 1'b1;
			next_r.hs.diow_n = 1'b1;
			next_r.hs.dior_n = next_r.state != ST_PIO;
		end

		// Endpoint buffer is kept while an OUT transfer may still read it
		// Held through a pending stop as well, since the burst still reads the buffer
		next_r.ep.keep = next_r.state == ST_XFER && !next_r.dir_in; // R06 R16
	end

	// ==========================================================
	// State register
	// One register for the whole image keeps pin reset and core reset identical
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			r <= RESET_VAL;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from the state flops
	// No path from a pin reaches a port within one cycle
	assign APB_RSP = r.rsp;
	assign HS      = r.hs;
	assign TF_ADDR = r.tfaddr;
	assign EP      = r.ep;

endmodule

// *** bench/dbc_ext_model.sv ***
/* External DMA controller model: drives the strobe and data pins.
   Assumes the bench raises want only after a core reset has ended. */
`timescale 1ns/100ps
module dbc_ext_model (
	input  wire logic             CLK,
	input  wire logic [7:0]       want,
	input  wire dbc_pkg::dbc_hs_t hs,
	input  wire logic [9:0]       tf,
	output logic                  stb,
	output logic [15:0]           data
);
	logic [7:0] done = 8'h00;
	logic [2:0] ph   = 3'h0;
	initial stb = 1'b0;
	initial data = 16'h0000;
	// Strobe 4 high, 4 low, started only while the device asks for bytes
	always @(posedge CLK) begin
		if (ph == 3'h0 && !(done != want && hs.dreq && hs.dack_n)) begin
			stb <= 1'b0;
			// Idle bus toggles so a stale value is never mistaken for data
			data <= (!hs.dior_n && hs.dack_n) ? ({6'h00, tf} ^ 16'h5a5a) : ~data;
		end else begin
			ph  <= ph + 3'h1;
			stb <= (ph < 3'h4);
			if (ph == 3'h0) begin
				data <= {8'h00, 8'h40 + done};
				done <= done + 8'h01;
			end
		end
	end
endmodule

// *** bench/dbc_core_asserts.sv ***
/* Port checker for the command decoder and byte counter.
   Assumes it is bound to dbc_core and sees only its ports. */
`timescale 1ns/100ps
module dbc_core_asserts (
	input wire logic                  CLK,
	input wire logic                  RST,
	input wire dbc_pkg::dbc_apb_req_t APB_REQ,
	input wire dbc_pkg::dbc_apb_rsp_t APB_RSP,
	input wire dbc_pkg::dbc_hs_t      HS,
	input wire logic [9:0]            TF_ADDR,
	input wire dbc_pkg::dbc_ep_t      EP
);
	import dbc_pkg::*;
	logic wr_cmd;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// ==========================================================
	// Accepted command write
	assign wr_cmd = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite
		&& APB_RSP.pready && APB_REQ.paddr == CMD_ADDR;
	chk_setup_ready: assert property (
		APB_REQ.psel && !APB_REQ.penable |=> APB_RSP.pready) else $error("no ready");
	chk_rst_glitch: assert property (
		wr_cmd && APB_REQ.pwdata[7:0] == CMD_CORE_RST |-> ##[1:3] !HS.dack_n)
		else $error("no reset pulse");
	chk_glitch_len: assert property (
		$fell(HS.dack_n) |-> !HS.dack_n [*4] ##1 HS.dack_n) else $error("pulse length");
	chk_glitch_all: assert property (
		!HS.dack_n |-> !HS.diow_n && !HS.dior_n && HS.dreq) else $error("pulse lines");
	chk_pio_start: assert property (
		wr_cmd && APB_REQ.pwdata[7:0] inside {[CMD_TF_FIRST:CMD_TF_LAST]}
		|-> ##[1:4] !HS.dior_n) else $error("no read strobe");
	chk_pio_strobe: assert property (
		$fell(HS.dior_n) && HS.dack_n |-> !HS.dior_n [*8]) else $error("strobe short");
	chk_tf_addr: assert property (
		!HS.dior_n && HS.dack_n |-> TF_ADDR inside {[10'h1f1:10'h1f6], 10'h3f6, 10'h3f7})
		else $error("bad task addr");
	chk_ep_pulse: assert property (
		EP.wr |-> EP.cnt inside {[4'h1:4'h8]} ##1 !EP.wr) else $error("bad flush");
endmodule
bind dbc_core dbc_core_asserts CHK (.CLK(CLK), .RST(RST), .APB_REQ(APB_REQ),
	.APB_RSP(APB_RSP), .HS(HS), .TF_ADDR(TF_ADDR), .EP(EP));

// *** bench/dbc_core_tb.sv ***
/* Self-checking bench for dbc_core with an external DMA model.
   Assumes the package constants and the APB timing of the core. */
`timescale 1ns/100ps
module dbc_core_tb;
	import dbc_pkg::*;
	logic         CLK = 1'b0;
	logic         RST = 1'b1;
	dbc_apb_req_t APB_REQ = '0;
	dbc_apb_rsp_t APB_RSP;
	logic         BUS_STROBE;
	logic [15:0]  BUS_DATA;
	dbc_hs_t      HS;
	logic [9:0]   TF_ADDR;
	dbc_ep_t      EP;
	logic [7:0]   want = 8'h00;
	logic [7:0]   in_idx = 8'h00;
	logic [31:0]  exp_q[$];
	logic [31:0]  v;
	logic [9:0]   a;
	logic         err_exp;
	logic [7:0]   rsv [4] = '{8'h14, 8'h20, 8'h29, 8'hff};
	int           errors = 0;
	int           n_tests = 0;
	int           cyc = 0;
	integer       seed = 32'ha75e;
	always #5 CLK = ~CLK;
	dbc_core DUT (.CLK(CLK), .RST(RST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
		.BUS_STROBE(BUS_STROBE), .BUS_DATA(BUS_DATA), .HS(HS), .TF_ADDR(TF_ADDR), .EP(EP));
	dbc_ext_model PEER (.CLK(CLK), .want(want), .hs(HS), .tf(TF_ADDR),
		.stb(BUS_STROBE), .data(BUS_DATA));
	// ==========================================================
	// Tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge CLK);
		APB_REQ <= '{1'b1, 1'b0, w, ad, d};
		@(posedge CLK);
		APB_REQ.penable <= 1'b1;
		do @(posedge CLK); while (APB_RSP.pready !== 1'b1); // Only the bench timeout ends a hang
		APB_REQ <= '0;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, ad, 32'h0);
	endtask
	// Ask the model for n strobes; the 12-cycle tail covers sync and flush age
	task automatic go(input int n);
		int k;
		@(posedge CLK);
		want <= want + n[7:0];
		for (k = 0; k < 12 * n + 20; k++) begin
			@(posedge CLK);
		end
		repeat (12) @(posedge CLK);
	endtask
	task summarize;
		$display("compares %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ==========================================================
	// Monitors: read data against the queue, flushed bytes in arrival order
	always @(posedge CLK) begin
		if (APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite && APB_RSP.pready)
			check(APB_RSP.prdata, exp_q.pop_front());
		// Every access answers with the error flag exactly for unmapped offsets
		err_exp = !(APB_REQ.paddr inside {CMD_ADDR, COUNTER_ADDR, CTRL_ADDR, STATUS_ADDR,
			TFDATA_ADDR});
		if (APB_REQ.psel && APB_REQ.penable && APB_RSP.pready)
			check({31'h0, APB_RSP.pslverr}, {31'h0, err_exp});
		if (EP.wr === 1'b1)
			for (int i = 0; i < EP.cnt; i++) begin
				check({24'h0, EP.data[8*i +: 8]}, {24'h0, 8'h40 + in_idx});
				in_idx = in_idx + 8'h01;
			end
		cyc++;
		if (cyc == 8000) begin
			errors++;
			summarize();
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge CLK);
		RST <= 1'b0;
		rd(COUNTER_ADDR, COUNTER_RST);
		rd(8'h50, 32'h0);
		v = $random(seed);
		wr(COUNTER_ADDR, v);
		rd(COUNTER_ADDR, v);
		wr(COUNTER_ADDR, 32'h5);
		in_idx = want;
		wr(CMD_ADDR, {24'h0, CMD_GEN_IN});
		go(5);
		rd(COUNTER_ADDR, 32'h0);
		wr(CTRL_ADDR, 32'h1);
		wr(COUNTER_ADDR, 32'h2);
		in_idx = want;
		wr(CMD_ADDR, {24'h0, CMD_GEN_IN});
		go(3);
		rd(COUNTER_ADDR, 32'hffff_ffff);
		// One more byte, stopped while it waits in the FIFO: the stop must drain it at once
		want <= want + 8'h01;
		@(posedge BUS_STROBE);
		repeat (3) @(posedge CLK);
		wr(CMD_ADDR, {24'h0, CMD_GEN_STOP});
		@(posedge CLK);
		check({31'h0, EP.wr}, 32'h1);
		rd(STATUS_ADDR, 32'h1);
		wr(STATUS_ADDR, 32'h1);
		wr(CTRL_ADDR, 32'h0);
		wr(COUNTER_ADDR, 32'h3);
		in_idx = want;
		wr(CMD_ADDR, {24'h0, CMD_MW_IN});
		go(1);
		wr(CMD_ADDR, {24'h0, CMD_MW_STOP});
		repeat (20) @(posedge CLK);
		check({31'h0, HS.dreq}, 32'h0);
		rd(COUNTER_ADDR, 32'h2);
		foreach (rsv[i]) begin
			wr(CMD_ADDR, {24'h0, rsv[i]});
			rd(CMD_ADDR, {24'h0, rsv[i]});
			rd(COUNTER_ADDR, 32'h2);
		end
		wr(CTRL_ADDR, 32'h0004_0000);
		wr(COUNTER_ADDR, 32'ha);
		wr(CMD_ADDR, {24'h0, CMD_GEN_OUT});
		go(2);
		check({31'h0, EP.keep}, 32'h1);
		wr(CMD_ADDR, {24'h0, CMD_GEN_STOP});
		go(2);
		rd(COUNTER_ADDR, 32'h6);
		rd(STATUS_ADDR, 32'h1);
		wr(STATUS_ADDR, 32'h1);
		for (int i = 0; i < 8; i++) begin
			a = (i < 6) ? 10'h1f1 + i[9:0] : 10'h3f0 + i[9:0];
			wr(CMD_ADDR, {24'h0, CMD_TF_FIRST + i[7:0]});
			repeat (PIO_CYC + 12) @(posedge CLK);
			rd(TFDATA_ADDR, {16'h0, {6'h00, a} ^ 16'h5a5a});
			rd(STATUS_ADDR, 32'h2);
			wr(STATUS_ADDR, 32'h2);
		end
		wr(CTRL_ADDR, 32'h1);
		wr(COUNTER_ADDR, $random(seed));
		wr(CMD_ADDR, {24'h0, CMD_CORE_RST});
		repeat (RST_CYC + 2) @(posedge CLK);
		rd(COUNTER_ADDR, COUNTER_RST);
		rd(CTRL_ADDR, 32'h0);
		summarize();
	end
endmodule
